// [verilog/iwdt_pkg.sv]
// Package: constants for the indexed watchdog timer
package iwdt_pkg;
    // I/O port addresses (index and data)
    localparam logic [15:0] INDEX_PORT = 16'h002E;
    localparam logic [15:0] DATA_PORT = 16'h002F;
    // Index-port key values
    localparam logic [7:0] UNLOCK_KEY = 8'h87;
    localparam logic [7:0] LOCK_KEY = 8'hAA;
    // Register indices
    localparam logic [7:0] REG_LDEV_SEL = 8'h07;
    localparam logic [7:0] REG_ACTIVATE = 8'h30;
    localparam logic [7:0] REG_UNIT_CFG = 8'hF5;
    localparam logic [7:0] REG_COUNT = 8'hF6;
    localparam logic [7:0] REG_CTRL_STAT = 8'hF7;
    // Logical device number of the watchdog
    localparam logic [7:0] WDT_LDEV = 8'h08;
    // Field positions
    localparam int ACT_EN_BIT = 0;
    localparam int UNIT_MIN_BIT = 3;
    localparam int UNIT_FAST_BIT = 4;
    localparam int CS_STATUS_BIT = 4;
    localparam int CS_FORCE_BIT = 5;
    localparam int CS_KBD_BIT = 6;
    localparam int CS_MOUSE_BIT = 7;
    // Reset values
    localparam logic [7:0] ACTIVATE_RST = 8'h00;
    localparam logic [7:0] UNIT_CFG_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CTRL_STAT_RST = 8'h00;
    localparam logic [7:0] LDEV_RST = 8'h00;
    // Timing: clock rate and time units
    localparam longint CLK_HZ = 25000000;
    localparam longint MS_PER_SEC = 1000;
    localparam longint SEC_PER_MIN = 60;
    localparam longint FAST_DIV = 1000;
    // Cycles in one millisecond; fast mode ticks per ms or per 60 ms, slow per second or per minute
    localparam logic [31:0] MS_CYCLES = 32'(CLK_HZ / MS_PER_SEC);
    localparam logic [31:0] SEC_MS = 32'(MS_PER_SEC);
    localparam logic [31:0] MIN_MS = 32'(MS_PER_SEC * SEC_PER_MIN);
    localparam logic [31:0] SEC_FAST_MS = 32'(MS_PER_SEC / FAST_DIV);
    localparam logic [31:0] MIN_FAST_MS =
        32'(MS_PER_SEC * SEC_PER_MIN / FAST_DIV);
endpackage

// [verilog/iwdt_tick.sv]
// Unit tick generator: one pulse per selected counting unit
`timescale 1ns/1ns
module iwdt_tick #(
    parameter logic [31:0] MS_CYCLES = iwdt_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic restart_in,
    input wire logic minutes_in,
    input wire logic fast_in,
    output logic tick_out
);
    logic [31:0] cyc_q;
    logic [31:0] ms_q;
    logic [31:0] ms_limit;
    logic ms_done;

    always_comb begin
        case ({minutes_in, fast_in})
            2'b00: ms_limit = iwdt_pkg::SEC_MS;
            2'b01: ms_limit = iwdt_pkg::SEC_FAST_MS;
            2'b10: ms_limit = iwdt_pkg::MIN_MS;
            default: ms_limit = iwdt_pkg::MIN_FAST_MS;
        endcase
    end

    assign ms_done = (cyc_q == MS_CYCLES - 32'h1);

    // Prescaler restarts with each reload so a unit is never short
    always_ff @(posedge clk_in) begin
        if (!rstn_in || !run_in || restart_in) begin
            cyc_q <= 32'h0;
        end else if (ms_done) begin
            cyc_q <= 32'h0;
        end else begin
            cyc_q <= cyc_q + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in || !run_in || restart_in) begin
            ms_q <= 32'h0;
            tick_out <= 1'b0;
        // Compare with >= so that a unit change in mid-count cannot
        // leave the millisecond counter above its new limit
        end else if (ms_done && ms_q >= ms_limit - 32'h1) begin
            ms_q <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            if (ms_done) begin
                ms_q <= ms_q + 32'h1;
            end
            tick_out <= 1'b0;
        end
    end
endmodule

// [verilog/iwdt_top.sv]
// Indexed watchdog timer reached through an index/data I/O port pair
`timescale 1ns/1ns
module iwdt_top #(
    parameter logic [31:0] MS_CYCLES = iwdt_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic kbd_activity_in,
    input wire logic mouse_activity_in,
    output logic [7:0] io_rdata_out,
    output logic timeout_out
);
    // ----------------------------------------------------------------
    // Configuration access state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CFG_LOCKED,
        CFG_HALF,
        CFG_OPEN
    } iwdt_cfg_e;

    iwdt_cfg_e cfg_q;
    logic [7:0] index_q;
    logic [7:0] ldev_q;
    logic [7:0] activate_q;
    logic [7:0] unit_q;
    logic [7:0] count_q;
    logic [7:0] remain_q;
    logic kbd_en_q;
    logic mouse_en_q;
    logic status_q;
    logic force_q;
    logic tick;

    logic idx_wr;
    logic dat_wr;
    logic dat_rd;
    logic wdt_sel;
    logic count_wr;
    logic ctrl_wr;
    logic enabled;
    logic restart;
    logic expire;

    function automatic logic reg_hit(input logic [7:0] idx,
                                     input logic [7:0] want);
        reg_hit = (idx == want);
    endfunction

    assign idx_wr = io_wr_in && io_addr_in == iwdt_pkg::INDEX_PORT;
    assign dat_wr = io_wr_in && io_addr_in == iwdt_pkg::DATA_PORT;
    assign dat_rd = io_rd_in && io_addr_in == iwdt_pkg::DATA_PORT;
    assign wdt_sel = (cfg_q == CFG_OPEN) &&
                     (ldev_q == iwdt_pkg::WDT_LDEV);
    assign count_wr = dat_wr && wdt_sel &&
                      reg_hit(index_q, iwdt_pkg::REG_COUNT);
    assign ctrl_wr = dat_wr && wdt_sel &&
                     reg_hit(index_q, iwdt_pkg::REG_CTRL_STAT);
    assign enabled = activate_q[iwdt_pkg::ACT_EN_BIT];

    // Key sequence: two unlock writes back to back on the index port
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cfg_q <= CFG_LOCKED;
        end else if (idx_wr) begin
            case (cfg_q)
                CFG_LOCKED: begin
                    if (io_wdata_in == iwdt_pkg::UNLOCK_KEY) begin
                        cfg_q <= CFG_HALF;
                    end
                end
                CFG_HALF: begin
                    if (io_wdata_in == iwdt_pkg::UNLOCK_KEY) begin
                        cfg_q <= CFG_OPEN;
                    end else begin
                        cfg_q <= CFG_LOCKED;
                    end
                end
                CFG_OPEN: begin
                    if (io_wdata_in == iwdt_pkg::LOCK_KEY) begin
                        cfg_q <= CFG_LOCKED;
                    end
                end
                default: cfg_q <= CFG_LOCKED;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Index latch and register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            index_q <= 8'h00;
        end else if (idx_wr && cfg_q == CFG_OPEN) begin
            index_q <= io_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ldev_q <= iwdt_pkg::LDEV_RST;
        end else if (dat_wr && cfg_q == CFG_OPEN &&
                     reg_hit(index_q, iwdt_pkg::REG_LDEV_SEL)) begin
            ldev_q <= io_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            activate_q <= iwdt_pkg::ACTIVATE_RST;
        end else if (dat_wr && wdt_sel &&
                     reg_hit(index_q, iwdt_pkg::REG_ACTIVATE)) begin
            activate_q <= io_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            unit_q <= iwdt_pkg::UNIT_CFG_RST;
        end else if (dat_wr && wdt_sel &&
                     reg_hit(index_q, iwdt_pkg::REG_UNIT_CFG)) begin
            unit_q <= io_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            count_q <= iwdt_pkg::COUNT_RST;
        end else if (count_wr) begin
            count_q <= io_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            kbd_en_q <= iwdt_pkg::CTRL_STAT_RST[iwdt_pkg::CS_KBD_BIT];
            mouse_en_q <= iwdt_pkg::CTRL_STAT_RST[iwdt_pkg::CS_MOUSE_BIT];
        end else if (ctrl_wr) begin
            kbd_en_q <= io_wdata_in[iwdt_pkg::CS_KBD_BIT];
            mouse_en_q <= io_wdata_in[iwdt_pkg::CS_MOUSE_BIT];
        end
    end

    // Force bit lives one cycle; the read path always returns zero for it
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            force_q <= 1'b0;
        end else begin
            force_q <= ctrl_wr &&
                       io_wdata_in[iwdt_pkg::CS_FORCE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Counting
    // ----------------------------------------------------------------
    assign restart = count_wr ||
                     (kbd_en_q && kbd_activity_in) ||
                     (mouse_en_q && mouse_activity_in);

    iwdt_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) i_iwdt_tick (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .run_in(enabled && remain_q != 8'h00),
        .restart_in(restart),
        .minutes_in(unit_q[iwdt_pkg::UNIT_MIN_BIT]),
        .fast_in(unit_q[iwdt_pkg::UNIT_FAST_BIT]),
        .tick_out(tick)
    );

    // A refresh on the expiry edge wins, as it reloads the count
    assign expire = enabled && tick && remain_q == 8'h01 && !restart;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            remain_q <= 8'h00;
        end else if (count_wr) begin
            remain_q <= io_wdata_in;
        end else if (restart) begin
            remain_q <= count_q;
        end else if (enabled && tick && remain_q != 8'h00) begin
            remain_q <= remain_q - 8'h01;
        end
    end

    // Status is sticky; software clears it by writing zero to bit 4,
    // but a timeout in the same cycle wins
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            status_q <= 1'b0;
        end else if (expire || force_q) begin
            status_q <= 1'b1;
        end else if (ctrl_wr && !io_wdata_in[iwdt_pkg::CS_STATUS_BIT]) begin
            status_q <= 1'b0;
        end
    end

    // Timeout output is a one-cycle pulse per expiry or forced event
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            timeout_out <= 1'b0;
        end else begin
            timeout_out <= expire || force_q;
        end
    end

    // ----------------------------------------------------------------
    // Data port reads
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            io_rdata_out <= 8'h00;
        end else if (dat_rd && cfg_q == CFG_OPEN) begin
            case (index_q)
                iwdt_pkg::REG_LDEV_SEL: io_rdata_out <= ldev_q;
                iwdt_pkg::REG_ACTIVATE:
                    io_rdata_out <= wdt_sel ? activate_q : 8'h00;
                iwdt_pkg::REG_UNIT_CFG:
                    io_rdata_out <= wdt_sel ? unit_q : 8'h00;
                iwdt_pkg::REG_COUNT:
                    io_rdata_out <= wdt_sel ? remain_q : 8'h00;
                iwdt_pkg::REG_CTRL_STAT:
                    io_rdata_out <= wdt_sel ?
                        {mouse_en_q, kbd_en_q, 1'b0, status_q, 4'h0} :
                        8'h00;
                default: io_rdata_out <= 8'h00;
            endcase
        end else begin
            io_rdata_out <= 8'h00;
        end
    end
endmodule

// [sim/iwdt_top_assertions.sv]
// Port checker for the indexed watchdog timer
`timescale 1ns/1ns
module iwdt_chk #(
    parameter logic [31:0] MS_CYCLES = iwdt_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic timeout_out
);
    // ----
    // Shadow of key sequence, index and device select
    // ----
    logic open_q;
    logic half_q;
    logic sel_q;
    logic [7:0] idx_q;
    logic iw;
    logic dw;
    logic dr;
    logic wcnt;
    logic wctl;
    assign iw = io_wr_in && io_addr_in == iwdt_pkg::INDEX_PORT;
    assign dw = io_wr_in && io_addr_in == iwdt_pkg::DATA_PORT && open_q;
    assign dr = io_rd_in && io_addr_in == iwdt_pkg::DATA_PORT;
    assign wcnt = dw && sel_q && idx_q == iwdt_pkg::REG_COUNT;
    assign wctl = dw && sel_q && idx_q == iwdt_pkg::REG_CTRL_STAT;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            open_q <= 1'b0;
            half_q <= 1'b0;
        end else if (iw && !open_q) begin
            half_q <= io_wdata_in == iwdt_pkg::UNLOCK_KEY && !half_q;
            open_q <= io_wdata_in == iwdt_pkg::UNLOCK_KEY && half_q;
        end else if (iw && io_wdata_in == iwdt_pkg::LOCK_KEY) begin
            open_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            idx_q <= 8'h00;
        end else if (iw && open_q) begin
            idx_q <= io_wdata_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sel_q <= 1'b0;
        end else if (dw && idx_q == iwdt_pkg::REG_LDEV_SEL) begin
            sel_q <= io_wdata_in == iwdt_pkg::WDT_LDEV;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    chk_rdata_idle: assert property (
        !io_rd_in |=> io_rdata_out == 8'h00)
        else $error("read data not idle");
    chk_locked_read: assert property (
        dr && !open_q |=> io_rdata_out == 8'h00)
        else $error("locked read not zero");
    chk_force_clear: assert property (
        dr && open_q && sel_q && idx_q == iwdt_pkg::REG_CTRL_STAT
        |=> !io_rdata_out[iwdt_pkg::CS_FORCE_BIT])
        else $error("force bit reads back set");
    chk_force_fire: assert property (
        wctl && io_wdata_in[iwdt_pkg::CS_FORCE_BIT] |-> ##2 timeout_out)
        else $error("forced timeout missing");
    chk_pulse_once: assert property (
        timeout_out |=> !timeout_out)
        else $error("timeout longer than a cycle");
    chk_reset_quiet: assert property (
        $rose(rstn_in) |-> !timeout_out [*8])
        else $error("timeout right after reset");
    chk_zero_stop: assert property (
        wcnt && io_wdata_in == 8'h00 |=> !timeout_out [*8])
        else $error("timeout with zero count");
    chk_reload_quiet: assert property (
        wcnt && io_wdata_in != 8'h00 |=> !timeout_out [*3])
        else $error("timeout right after reload");
endmodule
bind iwdt_top iwdt_chk #(.MS_CYCLES(MS_CYCLES)) i_iwdt_chk (.clk_in, .rstn_in,
    .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out,
    .timeout_out);

// [sim/iwdt_top_tb.sv]
// Self-checking bench for the indexed watchdog timer
`timescale 1ns/1ns
module iwdt_top_tb;
    localparam logic [31:0] MSC = 32'h4;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [15:0] io_addr_in = 16'h0000;
    logic io_wr_in = 1'b0;
    logic io_rd_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00;
    logic kbd_activity_in = 1'b0;
    logic mouse_activity_in = 1'b0;
    logic [7:0] io_rdata_out;
    logic timeout_out;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] lfsr = 32'h000142AA;
    logic [7:0] n;
    logic [7:0] act_cfg[3] = '{8'h40, 8'h80, 8'h00};
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_to = 0;
    int w;
    int t0;
    iwdt_top #(.MS_CYCLES(MSC)) i_iwdt_top (.clk_in, .rstn_in, .io_addr_in,
        .io_wr_in, .io_rd_in, .io_wdata_in, .kbd_activity_in,
        .mouse_activity_in, .io_rdata_out, .timeout_out);
    always #20 clk_in = ~clk_in;
    // ----
    // Helpers
    // ----
    task automatic check(input string s, input logic [7:0] seen,
                         input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, want, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Window allows for the tick phase and the registered pulse
    function automatic logic [7:0] in_win(input int v, input int c);
        return 8'(v >= c - 2 && v <= c + 4);
    endfunction
    task automatic io(input logic [15:0] a, input logic wr,
                      input logic [7:0] d);
        @(negedge clk_in);
        io_addr_in = a;
        io_wr_in = wr;
        io_rd_in = !wr;
        io_wdata_in = d;
        @(negedge clk_in);
        io_wr_in = 1'b0;
        io_rd_in = 1'b0;
    endtask
    task automatic key(input logic [7:0] k);
        io(iwdt_pkg::INDEX_PORT, 1'b1, k);
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        key(r);
        io(iwdt_pkg::DATA_PORT, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] e);
        key(r);
        exp_q.push_back(e);
        io(iwdt_pkg::DATA_PORT, 1'b0, 8'h00);
    endtask
    task automatic wait_to(input int lim, output int c);
        c = 0;
        while (timeout_out !== 1'b1 && c < lim) begin
            @(posedge clk_in);
            #1;
            c++;
        end
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        rd_q <= io_rd_in;
        if (timeout_out === 1'b1) begin
            n_to <= n_to + 1;
        end
        if (rd_q) begin
            check("read data", io_rdata_out, exp_q.pop_front());
        end
        if (cyc == 32'h2710) begin
            fails++;
            report_and_stop();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (6) @(negedge clk_in);
        rstn_in = 1'b1;
        rd(iwdt_pkg::REG_COUNT, 8'h00);
        key(iwdt_pkg::UNLOCK_KEY);
        key(iwdt_pkg::UNLOCK_KEY);
        wr(iwdt_pkg::REG_LDEV_SEL, iwdt_pkg::WDT_LDEV);
        rd(iwdt_pkg::REG_LDEV_SEL, iwdt_pkg::WDT_LDEV);
        rd(iwdt_pkg::REG_UNIT_CFG, 8'h00);
        rd(iwdt_pkg::REG_COUNT, 8'h00);
        rd(iwdt_pkg::REG_CTRL_STAT, 8'h00);
        wr(iwdt_pkg::REG_UNIT_CFG, 8'h10);
        wr(iwdt_pkg::REG_COUNT, 8'h01);
        t0 = n_to;
        repeat (40) @(negedge clk_in);
        check("disabled", 8'(n_to - t0), 8'h00);
        wr(iwdt_pkg::REG_COUNT, 8'h00);
        wr(iwdt_pkg::REG_ACTIVATE, 8'h01);
        t0 = n_to;
        repeat (40) @(negedge clk_in);
        check("stopped", 8'(n_to - t0), 8'h00);
        rd(iwdt_pkg::REG_COUNT, 8'h00);
        repeat (3) begin
            lfsr = step(lfsr);
            n = {4'h0, lfsr[3:0]} + 8'h01;
            wr(iwdt_pkg::REG_COUNT, n);
            wait_to(600, w);
            check("expiry", in_win(w, MSC * n), 8'h01);
        end
        rd(iwdt_pkg::REG_CTRL_STAT, 8'h10);
        for (int i = 0; i < 2; i++) begin
            wr(iwdt_pkg::REG_UNIT_CFG, i ? 8'h00 : 8'h18);
            wr(iwdt_pkg::REG_COUNT, 8'h01);
            wait_to(4100, w);
            t0 = i ? 1000 : 60;
            check("unit", in_win(w, t0 * MSC), 8'h01);
        end
        // Plain minutes: one count is far beyond this wait
        wr(iwdt_pkg::REG_UNIT_CFG, 8'h08);
        wr(iwdt_pkg::REG_COUNT, 8'h01);
        wait_to(300, w);
        check("minutes", 8'(w == 300), 8'h01);
        rd(iwdt_pkg::REG_COUNT, 8'h01);
        wr(iwdt_pkg::REG_CTRL_STAT, 8'h20);
        wait_to(8, w);
        check("forced", 8'(w <= 3), 8'h01);
        rd(iwdt_pkg::REG_CTRL_STAT, 8'h10);
        wr(iwdt_pkg::REG_UNIT_CFG, 8'h10);
        for (int i = 0; i < 3; i++) begin
            wr(iwdt_pkg::REG_CTRL_STAT, act_cfg[i]);
            wr(iwdt_pkg::REG_COUNT, 8'h04);
            t0 = n_to;
            repeat (6) begin
                repeat (9) @(negedge clk_in);
                kbd_activity_in = i != 1;
                mouse_activity_in = i == 1;
                @(negedge clk_in);
                kbd_activity_in = 1'b0;
                mouse_activity_in = 1'b0;
            end
            check("refresh", 8'(n_to - t0), 8'(i == 2));
            wait_to(40, w);
        end
        wr(iwdt_pkg::REG_LDEV_SEL, 8'h00);
        rd(iwdt_pkg::REG_CTRL_STAT, 8'h00);
        wr(iwdt_pkg::REG_LDEV_SEL, iwdt_pkg::WDT_LDEV);
        key(iwdt_pkg::LOCK_KEY);
        rd(iwdt_pkg::REG_LDEV_SEL, 8'h00);
        wr(iwdt_pkg::REG_COUNT, 8'h01);
        t0 = n_to;
        repeat (40) @(negedge clk_in);
        check("locked", 8'(n_to - t0), 8'h00);
        repeat (2) @(negedge clk_in);
        report_and_stop();
    end
endmodule
